// file: core/oag_pkg.sv
package oag_pkg;
  localparam int          AW           = 16;
  localparam logic [3:0]  MODE_X1_AL   = 4'h0;
  localparam logic [3:0]  MODE_X1_R0   = 4'h1;
  localparam logic [3:0]  MODE_SBA_FIX = 4'h2;
  localparam logic [3:0]  MODE_SBA_CUR = 4'h3;
  localparam logic [3:0]  MODE_IMM     = 4'h4;
  localparam logic [3:0]  MODE_TBL_DIR = 4'h5;
  localparam logic [3:0]  MODE_TBL_IND = 4'h6;
  localparam logic [3:0]  MODE_TBL_BAS = 4'h7;
  localparam logic [3:0]  MODE_NEAR    = 4'h8;
  localparam logic [3:0]  MODE_FAR     = 4'h9;
  localparam logic [3:0]  MODE_REL8    = 4'hA;
  localparam logic [3:0]  MODE_REL7    = 4'hB;
  localparam logic [3:0]  MODE_AREA_CALL_OP    = 4'hC;
  localparam logic [3:0]  MODE_VECTOR_CALL_OP    = 4'hD;
  localparam logic [3:0]  MODE_CIND    = 4'hE;
  localparam logic [3:0]  MODE_DATA    = 4'hF;
  localparam logic [2:0]  OP_SET_BIT   = 3'h1;
  localparam logic [2:0]  OP_CLR_BIT   = 3'h2;
  localparam logic [2:0]  OP_JBS       = 3'h3;
  localparam logic [2:0]  OP_JBC       = 3'h4;
  localparam logic [2:0]  OP_LCODE     = 3'h5;
  localparam logic [2:0]  OP_CMPCODE   = 3'h6;
  localparam logic [15:0] SBA_FIX_BASE = 16'h02C0;
  localparam logic [7:0]  SBA_LO_BASE  = 8'hC0;
  localparam logic [15:0] AREA_CALL_OP_BASE    = 16'h1000;
  localparam logic [15:0] VECTOR_CALL_OP_BASE    = 16'h004A;
  localparam logic [15:0] INH_LO       = 16'h0100;
  localparam logic [15:0] INH_HI       = 16'h01FF;
  localparam logic [15:0] ROMWIN_LO    = 16'h8000;
  localparam logic [15:0] ROMWIN_HI    = 16'hFFFF;
endpackage : oag_pkg

// file: core/oag_add16.sv
`timescale 1ns/1ps
module oag_add16 (
  input  wire logic [15:0] a,
  input  wire logic [15:0] b,
  output logic      [15:0] sum
);
  // carry dropped so sums wrap inside the 64K space
  logic [16:0] full;
  assign full = {1'b0, a} + {1'b0, b};
  assign sum  = full[15:0];
endmodule : oag_add16

// file: core/oag_region_chk.sv
`timescale 1ns/1ps
module oag_region_chk (
  input  wire logic [15:0] addr,
  output logic             inhibit,
  output logic             rom_window
);
  assign inhibit    = (addr >= oag_pkg::INH_LO) && (addr <= oag_pkg::INH_HI);
  assign rom_window = (addr >= oag_pkg::ROMWIN_LO) && (addr <= oag_pkg::ROMWIN_HI);
endmodule : oag_region_chk

// file: core/oag_addr_gen.sv
`timescale 1ns/1ps
// Notes on behaviour
// - index one plus zero-extended byte, wraps
// - word access clears address bit zero, except in the two bit areas
// - fixed bit area 2C0H.0 to 2FFH.7
// - current page bit area C0H..FFH
// - bit areas only for four bit ops
// - immediate: two code bytes word, one byte
// - table modes only for code load/compare
// - direct table offset from two bytes
// - indirect table uses fetched word pointer
// - base plus fetched word, wrapped
// - near target from two code bytes
// - far target from three code bytes
// - relative: pc plus 8 or 7-bit, wraps
// - area call 1000H plus 11-bit field
// - vector entries 004AH..0069H, segment zero
// - indirect code target from fetched word
// - rom window reads come from table segment
// - seven-bit displacement sign is bit 6
module oag_addr_gen (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        req,
  input  wire logic [3:0]  mode,
  input  wire logic [2:0]  op,
  input  wire logic        word_acc,
  input  wire logic        is_write,
  input  wire logic        use_disp7,
  input  wire logic [15:0] ptr_reg,
  input  wire logic [15:0] index_reg_one,
  input  wire logic [7:0]  accum_low_byte,
  input  wire logic [7:0]  local_reg_zero,
  input  wire logic [7:0]  page_sel,
  input  wire logic [15:0] pc,
  input  wire logic        code_seg,
  input  wire logic        table_segment_select,
  input  wire logic [15:0] fetched_word,
  input  wire logic [7:0]  code_b0,
  input  wire logic [7:0]  code_b1,
  input  wire logic [7:0]  code_b2,
  output logic             addr_valid,
  output logic [15:0]      addr,
  output logic [2:0]       bit_sel,
  output logic             seg_out,
  output logic             to_rom,
  output logic             data_side,
  output logic [1:0]       imm_bytes,
  output logic             mode_fault,
  output logic             inhibit_fault
);
  function automatic logic [15:0] sext7(input logic [6:0] f);
    sext7 = {{9{f[6]}}, f};
  endfunction : sext7

  logic [15:0] add_a;
  logic [15:0] add_b;
  logic [15:0] sum;
  logic        inh;
  logic        romw;
  logic [15:0] a_c;
  logic [2:0]  bit_c;
  logic        seg_c;
  logic        rom_c;
  logic        data_c;
  logic [1:0]  imm_c;
  logic        mf_c;
  logic        bit_op;
  logic        code_op;
  logic        addr_valid_nxt;
  logic [15:0] addr_nxt;
  logic [2:0]  bit_sel_nxt;
  logic        seg_out_nxt;
  logic        to_rom_nxt;
  logic        data_side_nxt;
  logic [1:0]  imm_bytes_nxt;
  logic        mode_fault_nxt;
  logic        inhibit_fault_nxt;
  logic [15:0] word_w;
  logic [15:0] code_w;

  assign word_w  = {code_b1, code_b0};
  assign code_w  = {code_b1, code_b0};
  assign bit_op  = (op == oag_pkg::OP_SET_BIT) || (op == oag_pkg::OP_CLR_BIT)
                || (op == oag_pkg::OP_JBS) || (op == oag_pkg::OP_JBC);
  assign code_op = (op == oag_pkg::OP_LCODE) || (op == oag_pkg::OP_CMPCODE);

  oag_add16 u_add (
    .a   (add_a),
    .b   (add_b),
    .sum (sum)
  );

  oag_region_chk u_reg (
    .addr       (a_c),
    .inhibit    (inh),
    .rom_window (romw)
  );

  // adder operand selection
  always_comb begin
    add_a = ptr_reg;
    add_b = 16'h0000;
    case (mode)
      oag_pkg::MODE_X1_AL: begin
        add_a = index_reg_one;
        add_b = {8'h00, accum_low_byte};
      end
      oag_pkg::MODE_X1_R0: begin
        add_a = index_reg_one;
        add_b = {8'h00, local_reg_zero};
      end
      oag_pkg::MODE_TBL_BAS: begin
        add_a = word_w;
        add_b = fetched_word;
      end
      oag_pkg::MODE_REL8: begin
        add_a = pc;
        add_b = {8'h00, code_b0};
      end
      oag_pkg::MODE_REL7: begin
        add_a = pc;
        add_b = sext7(code_b0[6:0]);
      end
      oag_pkg::MODE_DATA: begin
        add_a = ptr_reg;
        add_b = use_disp7 ? sext7(code_b0[6:0]) : 16'h0000;
      end
      default: begin
        add_a = ptr_reg;
        add_b = 16'h0000;
      end
    endcase
  end

  // address formation per mode
  always_comb begin
    a_c    = 16'h0000;
    bit_c  = 3'h0;
    seg_c  = code_seg;
    rom_c  = 1'b0;
    data_c = 1'b1;
    imm_c  = 2'h0;
    mf_c   = 1'b0;
    case (mode)
      oag_pkg::MODE_X1_AL, oag_pkg::MODE_X1_R0, oag_pkg::MODE_DATA: begin
        a_c = sum;
      end
      oag_pkg::MODE_SBA_FIX: begin
        // code_b1[0] is bit 8 of the bit number, so all 512 bits are reachable
        a_c   = oag_pkg::SBA_FIX_BASE + {10'h000, code_b1[0], code_b0[7:3]};
        bit_c = code_b0[2:0];
        mf_c  = !bit_op;
      end
      oag_pkg::MODE_SBA_CUR: begin
        a_c   = {page_sel, oag_pkg::SBA_LO_BASE + {2'h0, code_b1[0], code_b0[7:3]}};
        bit_c = code_b0[2:0];
        mf_c  = !bit_op;
      end
      oag_pkg::MODE_IMM: begin
        data_c = 1'b0;
        rom_c  = 1'b1;
        a_c    = pc;
        imm_c  = word_acc ? 2'h2 : 2'h1;
      end
      oag_pkg::MODE_TBL_DIR: begin
        data_c = 1'b0;
        rom_c  = 1'b1;
        seg_c  = table_segment_select;
        a_c    = word_w;
        mf_c   = !code_op;
      end
      oag_pkg::MODE_TBL_IND: begin
        data_c = 1'b0;
        rom_c  = 1'b1;
        seg_c  = table_segment_select;
        a_c    = fetched_word;
        mf_c   = !code_op;
      end
      oag_pkg::MODE_TBL_BAS: begin
        data_c = 1'b0;
        rom_c  = 1'b1;
        seg_c  = table_segment_select;
        a_c    = sum;
        mf_c   = !code_op;
      end
      oag_pkg::MODE_NEAR: begin
        data_c = 1'b0;
        rom_c  = 1'b1;
        a_c    = code_w;
      end
      oag_pkg::MODE_FAR: begin
        data_c = 1'b0;
        rom_c  = 1'b1;
        seg_c  = code_b2[0];
        a_c    = code_w;
      end
      oag_pkg::MODE_REL8, oag_pkg::MODE_REL7: begin
        data_c = 1'b0;
        rom_c  = 1'b1;
        a_c    = sum;
      end
      oag_pkg::MODE_AREA_CALL_OP: begin
        data_c = 1'b0;
        rom_c  = 1'b1;
        a_c    = oag_pkg::AREA_CALL_OP_BASE | {5'h00, code_b1[2:0], code_b0};
      end
      oag_pkg::MODE_VECTOR_CALL_OP: begin
        data_c = 1'b0;
        rom_c  = 1'b1;
        seg_c  = 1'b0;
        a_c    = oag_pkg::VECTOR_CALL_OP_BASE + {11'h000, code_b0[3:0], 1'b0};
      end
      oag_pkg::MODE_CIND: begin
        data_c = 1'b0;
        rom_c  = 1'b1;
        a_c    = fetched_word;
      end
      default: begin
        a_c = sum;
      end
    endcase
  end

  // register the result; one cycle after req
  always_comb begin
    addr_valid_nxt    = 1'b0;
    addr_nxt          = addr;
    bit_sel_nxt       = bit_sel;
    seg_out_nxt       = seg_out;
    to_rom_nxt        = to_rom;
    data_side_nxt     = data_side;
    imm_bytes_nxt     = imm_bytes;
    mode_fault_nxt    = 1'b0;
    inhibit_fault_nxt = 1'b0;
    if (req) begin
      addr_nxt      = (word_acc && mode != oag_pkg::MODE_SBA_FIX
                       && mode != oag_pkg::MODE_SBA_CUR) ? {a_c[15:1], 1'b0} : a_c;
      bit_sel_nxt   = bit_c;
      seg_out_nxt   = seg_c;
      imm_bytes_nxt = imm_c;
      data_side_nxt = data_c;
      // rom window: reads go to table segment, writes unguaranteed
      to_rom_nxt    = rom_c || (data_c && romw && !is_write);
      if (data_c && romw && !is_write) begin
        seg_out_nxt = table_segment_select;
      end
      mode_fault_nxt    = mf_c;
      inhibit_fault_nxt = data_c && inh;
      addr_valid_nxt    = !mf_c && !(data_c && inh);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      addr_valid    <= 1'b0;
      addr          <= 16'h0000;
      bit_sel       <= 3'h0;
      seg_out       <= 1'b0;
      to_rom        <= 1'b0;
      data_side     <= 1'b0;
      imm_bytes     <= 2'h0;
      mode_fault    <= 1'b0;
      inhibit_fault <= 1'b0;
    end else begin
      addr_valid    <= addr_valid_nxt;
      addr          <= addr_nxt;
      bit_sel       <= bit_sel_nxt;
      seg_out       <= seg_out_nxt;
      to_rom        <= to_rom_nxt;
      data_side     <= data_side_nxt;
      imm_bytes     <= imm_bytes_nxt;
      mode_fault    <= mode_fault_nxt;
      inhibit_fault <= inhibit_fault_nxt;
    end
  end

  a_x1_wrap: assert property (@(posedge mclk) disable iff (reset)
    req && mode == oag_pkg::MODE_X1_AL && !word_acc |=>
      addr == $past(index_reg_one) + {8'h00, $past(accum_low_byte)})
    else $error("indexed address wrong");

  a_word_even: assert property (@(posedge mclk) disable iff (reset)
    req && word_acc |=> !addr[0] || $past(mode) == oag_pkg::MODE_SBA_FIX
      || $past(mode) == oag_pkg::MODE_SBA_CUR)
    else $error("word address odd");

  a_sba_fix_range: assert property (@(posedge mclk) disable iff (reset)
    req && mode == oag_pkg::MODE_SBA_FIX |=> addr[15:6] == 10'h00B)
    else $error("fixed bit area out of range");

  a_sba_page: assert property (@(posedge mclk) disable iff (reset)
    req && mode == oag_pkg::MODE_SBA_CUR |=> addr[15:8] == $past(page_sel)
      && addr[7:6] == 2'h3)
    else $error("page bit area wrong");

  a_sba_ops: assert property (@(posedge mclk) disable iff (reset)
    req && mode == oag_pkg::MODE_SBA_FIX && !bit_op |=> mode_fault && !addr_valid)
    else $error("bit area misuse not flagged");

  a_imm_count: assert property (@(posedge mclk) disable iff (reset)
    req && mode == oag_pkg::MODE_IMM |=> imm_bytes == ($past(word_acc) ? 2'h2 : 2'h1))
    else $error("immediate byte count wrong");

  a_tbl_seg: assert property (@(posedge mclk) disable iff (reset)
    req && mode == oag_pkg::MODE_TBL_IND && code_op |=>
      addr_valid && to_rom && seg_out == $past(table_segment_select))
    else $error("table segment not used");

  a_vector_call_op_range: assert property (@(posedge mclk) disable iff (reset)
    req && mode == oag_pkg::MODE_VECTOR_CALL_OP |=> addr >= 16'h004A && addr <= 16'h0069
      && !seg_out)
    else $error("vector entry out of range");

  a_area_call_op_area: assert property (@(posedge mclk) disable iff (reset)
    req && mode == oag_pkg::MODE_AREA_CALL_OP |=> addr >= 16'h1000 && addr <= 16'h17FF)
    else $error("area call target out of range");

  a_inh_flag: assert property (@(posedge mclk) disable iff (reset)
    inhibit_fault |-> !addr_valid)
    else $error("inhibited address driven");
endmodule : oag_addr_gen

// file: test/oag_mem_model.sv
`timescale 1ns/1ps
// data memory stand-in: latches a word for each data-side address
module oag_mem_model (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        addr_valid,
  input  wire logic        data_side,
  input  wire logic [15:0] addr,
  output logic      [15:0] word_out
);
  logic [15:0] word_nxt;
  // contents scrambled from the address so a wrong pointer shows up
  always_comb begin
    word_nxt = word_out;
    if (addr_valid && data_side) begin
      word_nxt = {addr[7:0] ^ 8'h5A, addr[15:8]};
    end
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) word_out <= 16'h0000;
    else       word_out <= word_nxt;
  end
endmodule : oag_mem_model

// file: test/oag_addr_gen_tb.sv
`timescale 1ns/1ps
module oag_addr_gen_tb;
  localparam logic [26:0] MD = 27'h760FFFF;
  localparam logic [26:0] MB = 27'h767FFFF;
  localparam logic [26:0] MI = 27'h7180000;
  localparam logic [26:0] MT = 27'h7C0FFFF;
  localparam logic [26:0] MW = 27'h740FFFF;
  localparam logic [26:0] MC = 27'h7E0FFFF;
  localparam logic [26:0] MF = 27'h7000000;
  logic mclk = 0, reset = 1, req = 0, wa = 0, wr = 0, d7 = 0, cseg = 0;
  logic [3:0] mode = 0;
  logic [2:0] op = 0, bit_sel;
  logic [15:0] a16 = 0, fw, addr;
  logic [7:0] b8 = 0, b0 = 0, b1 = 0, b2 = 0;
  logic av, mf, inf, seg, rom, ds;
  logic [1:0] imm;
  logic [26:0] r;
  int n_errors = 0, num_checks = 0;
  assign r = {av, mf, inf, seg, rom, ds, imm, bit_sel, addr};
  always #5 mclk = ~mclk;
  oag_addr_gen u_oag_addr_gen (.mclk(mclk), .reset(reset), .req(req), .mode(mode), .op(op),
    .word_acc(wa), .is_write(wr), .use_disp7(d7), .ptr_reg(a16), .index_reg_one(a16),
    .accum_low_byte(b8), .local_reg_zero(~b8), .page_sel(b8), .pc(a16), .code_seg(cseg),
    .table_segment_select(~cseg), .fetched_word(fw), .code_b0(b0), .code_b1(b1),
    .code_b2(b2), .addr_valid(av), .addr(addr), .bit_sel(bit_sel), .seg_out(seg),
    .to_rom(rom), .data_side(ds), .imm_bytes(imm), .mode_fault(mf), .inhibit_fault(inf));
  oag_mem_model u_oag_mem_model (.mclk(mclk), .reset(reset), .addr_valid(av),
    .data_side(ds), .addr(addr), .word_out(fw));
  function automatic logic [26:0] ex(logic [5:0] f, logic [1:0] i, logic [2:0] b,
                                     logic [15:0] a);
    return {f, i, b, a};
  endfunction : ex
  task automatic chk(input logic [26:0] e, input logic [26:0] m);
    num_checks++;
    if ((r & m) !== (e & m)) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, r & m, e & m);
    end
  endtask : chk
  // one request, answer sampled once the following edge has landed
  task automatic go(input logic [3:0] m, input logic [2:0] o, input logic [2:0] f,
                    input logic [15:0] a, input logic [7:0] b, input logic [23:0] cb);
    @(posedge mclk);
    req <= 1'b1;
    mode <= m;
    op <= o;
    {wa, wr, d7} <= f;
    a16 <= a;
    b8 <= b;
    {b2, b1, b0} <= cb;
    @(posedge mclk);
    req <= 1'b0;
    #1;
  endtask : go
  task automatic t_index;
    go(oag_pkg::MODE_X1_AL, 0, 3'b100, 16'hFFF0, 8'hFF, 0);
    chk(ex(6'b100001, 0, 0, 16'h00EE), MD);
    go(oag_pkg::MODE_X1_R0, 0, 0, 16'h1234, 8'h00, 0);
    chk(ex(6'b100001, 0, 0, 16'h1333), MD);
    go(oag_pkg::MODE_X1_AL, 0, 0, 16'hFFFF, 8'h01, 0);
    chk(ex(6'b100001, 0, 0, 16'h0000), MD);
    @(posedge mclk);
    #1;
    chk(0, MF);
  endtask : t_index
  task automatic t_bits;
    go(oag_pkg::MODE_SBA_FIX, oag_pkg::OP_SET_BIT, 0, 0, 0, 24'hFF);
    chk(ex(6'b100001, 0, 7, 16'h02DF), MB);
    go(oag_pkg::MODE_SBA_CUR, oag_pkg::OP_JBC, 0, 0, 8'h47, 24'h0A);
    chk(ex(6'b100001, 0, 2, 16'h47C1), MB);
    go(oag_pkg::MODE_SBA_FIX, oag_pkg::OP_CLR_BIT, 0, 0, 0, 24'h00);
    chk(ex(6'b100001, 0, 0, 16'h02C0), MB);
    go(oag_pkg::MODE_SBA_CUR, oag_pkg::OP_JBS, 0, 0, 8'h20, 24'hF9);
    chk(ex(6'b100001, 0, 1, 16'h20DF), MB);
    go(oag_pkg::MODE_SBA_FIX, oag_pkg::OP_JBC, 0, 0, 0, 24'h1FF);
    chk(ex(6'b100001, 0, 7, 16'h02FF), MB);
    go(oag_pkg::MODE_SBA_FIX, oag_pkg::OP_LCODE, 0, 0, 0, 24'hFF);
    chk(ex(6'b010000, 0, 0, 0), MF);
  endtask : t_bits
  task automatic t_imm;
    go(oag_pkg::MODE_IMM, 0, 3'b100, 0, 0, 0);
    chk(ex(6'b100000, 2, 0, 0), MI);
    go(oag_pkg::MODE_IMM, 0, 0, 0, 0, 0);
    chk(ex(6'b100000, 1, 0, 0), MI);
  endtask : t_imm
  // pointer word comes through the memory model, not from the bench
  task automatic t_table;
    go(oag_pkg::MODE_TBL_DIR, oag_pkg::OP_LCODE, 0, 0, 0, 24'hABCD);
    chk(ex(6'b100110, 0, 0, 16'hABCD), MT);
    go(oag_pkg::MODE_TBL_DIR, 0, 0, 0, 0, 24'hABCD);
    chk(ex(6'b010000, 0, 0, 0), MF);
    go(oag_pkg::MODE_DATA, 0, 0, 16'h2468, 0, 0);
    go(oag_pkg::MODE_TBL_IND, oag_pkg::OP_CMPCODE, 0, 0, 0, 0);
    chk(ex(6'b100110, 0, 0, 16'h3224), MT);
    go(oag_pkg::MODE_TBL_BAS, oag_pkg::OP_LCODE, 0, 0, 0, 24'hFFFF);
    chk(ex(6'b100110, 0, 0, 16'h3223), MT);
    go(oag_pkg::MODE_CIND, 0, 0, 0, 0, 0);
    chk(ex(6'b100010, 0, 0, 16'h3224), MC);
  endtask : t_table
  // code segment 1, table segment 0, so each mode shows which one it picked
  task automatic t_code;
    @(posedge mclk);
    cseg <= 1'b1;
    go(oag_pkg::MODE_NEAR, 0, 0, 0, 0, 24'hABCD);
    chk(ex(6'b100110, 0, 0, 16'hABCD), MC);
    go(oag_pkg::MODE_FAR, 0, 0, 0, 0, 24'h013000);
    chk(ex(6'b100110, 0, 0, 16'h3000), MC);
    go(oag_pkg::MODE_FAR, 0, 0, 0, 0, 24'h00FFFF);
    chk(ex(6'b100010, 0, 0, 16'hFFFF), MC);
    go(oag_pkg::MODE_REL8, 0, 0, 16'hFFF0, 0, 24'h20);
    chk(ex(6'b100110, 0, 0, 16'h0010), MC);
    go(oag_pkg::MODE_REL7, 0, 0, 16'h1000, 0, 24'h40);
    chk(ex(6'b100110, 0, 0, 16'h0FC0), MC);
    go(oag_pkg::MODE_AREA_CALL_OP, 0, 0, 0, 0, 24'h07FF);
    chk(ex(6'b100110, 0, 0, 16'h17FF), MC);
    go(oag_pkg::MODE_VECTOR_CALL_OP, 0, 0, 0, 0, 24'h0F);
    chk(ex(6'b100010, 0, 0, 16'h0068), MC);
  endtask : t_code
  task automatic t_regions;
    @(posedge mclk);
    cseg <= 1'b0;
    go(oag_pkg::MODE_DATA, 0, 3'b001, 16'h1000, 0, 24'h7F);
    chk(ex(6'b100001, 0, 0, 16'h0FFF), MD);
    go(oag_pkg::MODE_DATA, 0, 3'b001, 16'h1000, 0, 24'h3F);
    chk(ex(6'b100001, 0, 0, 16'h103F), MD);
    go(oag_pkg::MODE_DATA, 0, 0, 16'h9000, 0, 0);
    chk(ex(6'b100110, 0, 0, 16'h9000), MT);
    go(oag_pkg::MODE_DATA, 0, 3'b010, 16'h9000, 0, 0);
    chk(ex(6'b100000, 0, 0, 16'h9000), MW);
    go(oag_pkg::MODE_DATA, 0, 0, 16'h0150, 0, 0);
    chk(ex(6'b001000, 0, 0, 0), MF);
  endtask : t_regions
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (2) @(posedge mclk);
    #1;
    chk(0, 27'h7FFFFFF);
    @(posedge mclk);
    reset <= 1'b0;
    t_index();
    t_bits();
    t_imm();
    t_table();
    t_code();
    t_regions();
    summarize();
  end
  // hang guard: the whole run needs far fewer cycles
  initial begin
    repeat (2000) @(posedge mclk);
    n_errors++;
    summarize();
  end
endmodule : oag_addr_gen_tb
